// ===== bench/ajs_jtag_ctl.sv
// external test controller model driving the test port
`timescale 1ns/10ps
module ajs_jtag_ctl
(
    input  wire logic clk_i,
    input  wire logic tdo_i,
    input  wire logic tdo_oe_i,
    output logic      tck_o,
    output logic      tms_o,
    output logic      tdi_o,
    output logic      alt_o
);
    logic tdo_seen;
    initial
    begin
        tck_o = 1'b0;
        tms_o = 1'b1;
        tdi_o = 1'b0;
        alt_o = 1'b1;
    end
    // one test clock of 8 system clocks, stands low between steps
    task automatic step(input logic t, input logic d, input logic a);
        @(posedge clk_i);
        tms_o <= t;
        tdi_o <= d;
        alt_o <= a;
        repeat (3) @(posedge clk_i);
        // released pin reads as the inverse of its last value
        tdo_seen = tdo_oe_i ? tdo_i : !tdo_i;
        tck_o <= 1'b1;
        repeat (4) @(posedge clk_i);
        tck_o <= 1'b0;
    endtask
    task automatic tap_reset();
        repeat (5) step(1'b1, 1'b0, 1'b1);
        step(1'b0, 1'b1, 1'b0);
    endtask
    // identify load by mode line only, data lines toggling
    task automatic id_load();
        logic [5:0] p;
        p = 6'b110110;
        for (int i = 5; i >= 0; i--) step(p[i], i[0], !i[0]);
    endtask
    // instruction on the chosen pin lsb first, inverse on the other
    task automatic load_ir(input logic [7:0] v, input logic use_alt);
        logic [3:0] p;
        p = 4'b1100;
        for (int i = 3; i >= 0; i--) step(p[i], 1'b0, 1'b1);
        for (int i = 0; i < 8; i++)
            step(i == 7, v[i] ^ use_alt, v[i] ^ !use_alt);
        step(1'b1, 1'b0, 1'b1);
        step(1'b0, 1'b0, 1'b1);
    endtask
    // identification register read from idle, lsb first
    task automatic read_dr(output logic [31:0] v);
        step(1'b1, 1'b0, 1'b1);
        step(1'b0, 1'b0, 1'b1);
        step(1'b0, 1'b0, 1'b1);
        for (int i = 0; i < 32; i++)
        begin
            step(i == 31, 1'b0, 1'b1);
            v[i] = tdo_seen;
        end
        step(1'b1, 1'b0, 1'b1);
        step(1'b0, 1'b0, 1'b1);
    endtask
endmodule // ajs_jtag_ctl

// ===== bench/ajs_select_assertions.sv
// port assertions for the data input selector
`timescale 1ns/10ps
module ajs_chk
(
    input wire logic                       clk_i,
    input wire logic                       rst_i,
    input wire logic                       wb_cyc_i,
    input wire logic                       wb_stb_i,
    input wire logic                       wb_ack_o,
    input wire logic                       data_input_select_pin_i,
    input wire logic                       alternate_active_o,
    input wire logic                       alternate_programming_supply_i,
    input wire logic [ajs_pkg::N_OUT-1:0]  pin_oe_o,
    input wire logic [ajs_pkg::N_HV-1:0]   core_hv_i,
    input wire logic [ajs_pkg::N_HV-1:0]   high_voltage_gate_output_o,
    input wire logic [ajs_pkg::N_IN-1:0]   core_in_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic [2:0] hi_n;
    logic [2:0] lo_n;
    logic [2:0] sel_n;
    // saturating run length of a steady level
    function automatic logic [2:0] up(input logic [2:0] c, input logic on);
        return on ? c + {2'h0, c != 3'h7} : 3'h0;
    endfunction
    always_ff @(posedge clk_i)
        hi_n <= rst_i ? 3'h0 : up(hi_n, alternate_programming_supply_i);
    always_ff @(posedge clk_i)
        lo_n <= rst_i ? 3'h0 : up(lo_n, !alternate_programming_supply_i);
    always_ff @(posedge clk_i)
        sel_n <= rst_i ? 3'h0 : up(sel_n, !data_input_select_pin_i);
    chk_hv_supply_low: assert property (hi_n >= 3'h4
        |-> high_voltage_gate_output_o == '0) else $error("hv not low");
    chk_oe_supply_off: assert property (hi_n >= 3'h4
        |-> pin_oe_o == '0) else $error("outputs not floating");
    chk_in_supply_off: assert property (hi_n >= 3'h4
        |-> core_in_o == '0) else $error("inputs not ignored");
    chk_hv_follow: assert property (lo_n >= 3'h4
        |-> high_voltage_gate_output_o == $past(core_hv_i))
        else $error("hv does not follow core");
    chk_sel_low_alt: assert property (sel_n >= 3'h4
        |-> alternate_active_o) else $error("select low not alternate");
    chk_ack_delay: assert property ($rose(wb_cyc_i && wb_stb_i)
        |-> !wb_ack_o ##1 !wb_ack_o ##1 wb_ack_o) else $error("ack late");
    chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    chk_ack_cause: assert property (wb_ack_o
        |-> $past(wb_cyc_i && wb_stb_i, 2)) else $error("ack unasked");
endmodule // ajs_chk
bind ajs_select ajs_chk u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
    .wb_ack_o, .data_input_select_pin_i, .alternate_active_o,
    .alternate_programming_supply_i, .pin_oe_o, .core_hv_i,
    .high_voltage_gate_output_o, .core_in_o);

// ===== bench/tb_ajs_select.sv
// self-checking bench for the data input selector
`timescale 1ns/10ps
module tb_ajs_select;
    logic        clk_i, rst_i, cyc, stb, we, sel_pin, alternate_programming_supply, ack;
    logic        tck, tms, tdi, alt, alt_act, tdo, tdo_oe;
    logic [3:0]  adr, sel, pin_in, core_in;
    logic [31:0] wdat, rdat, q;
    logic [11:0] c_out, c_oe, p_out, p_oe;
    logic [1:0]  c_hv, hv;
    int          n_mismatch = 0;
    int          checks = 0;
    initial
    begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    ajs_jtag_ctl u_ctl (.clk_i, .tck_o(tck), .tms_o(tms), .tdi_o(tdi),
        .alt_o(alt), .tdo_i(tdo), .tdo_oe_i(tdo_oe));
    ajs_select DUT (.clk_i, .rst_i, .ce_i(1'b1), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .tck_i(tck),
        .tms_i(tms), .tdi_i(tdi), .alternate_data_input_i(alt),
        .data_input_select_pin_i(sel_pin), .tdo_o(tdo), .tdo_oe_o(tdo_oe),
        .alternate_active_o(alt_act),
        .alternate_programming_supply_i(alternate_programming_supply), .core_out_i(c_out),
        .core_oe_i(c_oe), .pin_out_o(p_out), .pin_oe_o(p_oe),
        .core_hv_i(c_hv), .high_voltage_gate_output_o(hv),
        .pin_in_i(pin_in), .core_in_o(core_in));
    task automatic end_of_test();
        if (n_mismatch == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic w, input logic [3:0] a,
        input logic [31:0] d);
        int n;
        @(posedge clk_i);
        {cyc, stb, we, adr, sel, wdat} <= {2'h3, w, a, 4'hF, d};
        n = 0;
        do @(posedge clk_i); while (ack !== 1'b1 && ++n < 20);
        q = rdat;
        {cyc, stb} <= 2'h0;
        if (n >= 20)
        begin
            n_mismatch++;
            end_of_test();
        end
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        wb(1'b0, a, 32'h0);
        chk(q, exp);
    endtask
    initial
    begin
        {rst_i, cyc, stb, we, sel_pin, alternate_programming_supply} = 6'h22;
        {adr, sel, wdat} = 40'h0;
        {c_out, c_oe, c_hv, pin_in} = {12'hA5C, 12'hF0F, 2'h2, 4'h9};
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(ajs_pkg::ADR_STATUS, 32'h0000_1602);
        u_ctl.tap_reset();
        repeat (3) u_ctl.id_load();
        rd(ajs_pkg::ADR_STATUS, 32'h0000_1632);
        u_ctl.load_ir(8'hFF, 1'b0);
        rd(ajs_pkg::ADR_STATUS, 32'h0000_FF02);
        repeat (4) u_ctl.id_load();
        rd(ajs_pkg::ADR_STATUS, 32'h0000_1643);
        u_ctl.load_ir(8'h3C, 1'b1);
        rd(ajs_pkg::ADR_STATUS, 32'h0000_3C03);
        u_ctl.tap_reset();
        rd(ajs_pkg::ADR_STATUS, 32'h0000_1602);
        u_ctl.read_dr(q);
        chk(q, ajs_pkg::ID_CODE_VALUE);
        chk(tdo_oe, 1'b0);
        u_ctl.load_ir(8'h55, 1'b0);
        rd(ajs_pkg::ADR_STATUS, 32'h0000_5502);
        sel_pin <= 1'b0;
        u_ctl.load_ir(8'hC3, 1'b1);
        chk(alt_act, 1'b1);
        rd(ajs_pkg::ADR_STATUS, 32'h0000_C301);
        sel_pin <= 1'b1;
        repeat (6) @(posedge clk_i);
        rd(ajs_pkg::ADR_STATUS, 32'h0000_C302);
        chk({p_out, p_oe}, {c_out, c_oe});
        chk({hv, core_in}, {c_hv, pin_in});
        alternate_programming_supply <= 1'b1;
        repeat (6) @(posedge clk_i);
        chk({p_oe, hv, core_in}, 18'h0);
        rd(ajs_pkg::ADR_STATUS, 32'h0000_C30A);
        alternate_programming_supply <= 1'b0;
        wb(1'b1, ajs_pkg::ADR_CONFIG, 32'hA5A5_1234);
        rd(ajs_pkg::ADR_CONFIG, 32'hA5A5_1234);
        wb(1'b1, ajs_pkg::ADR_SIGNATURE, 32'hCAFE_F00D);
        rd(ajs_pkg::ADR_SIGNATURE, 32'hCAFE_F00D);
        wb(1'b1, ajs_pkg::ADR_STATUS, 32'hFFFF_FFFF);
        wb(1'b1, ajs_pkg::ADR_COMMAND, 32'h1);
        rd(ajs_pkg::ADR_CONFIG, 32'h0);
        rd(ajs_pkg::ADR_STATUS, 32'h0000_C306);
        wb(1'b1, ajs_pkg::ADR_COMMAND, 32'h3);
        rd(ajs_pkg::ADR_STATUS, 32'h0000_C302);
        rd(ajs_pkg::ADR_CONFIG, 32'h0);
        wb(1'b1, ajs_pkg::ADR_CONFIG, 32'h0F0F_0F0F);
        rd(ajs_pkg::ADR_CONFIG, 32'h0F0F_0F0F);
        rd(ajs_pkg::ADR_SIGNATURE, 32'hCAFE_F00D);
        end_of_test();
    end
endmodule // tb_ajs_select

// ===== core/ajs_nv_store.sv
// nonvolatile word store: configuration and user signature
`timescale 1ns/10ps
module ajs_nv_store
(
    input  wire logic                       clk_i,
    input  wire logic                       ce_i,
    input  wire logic                       we_i,
    input  wire logic [ajs_pkg::SEL_W-1:0]  be_i,
    input  wire logic                       addr_i,
    input  wire logic [ajs_pkg::WORD_W-1:0] wdata_i,
    output logic      [ajs_pkg::WORD_W-1:0] rdata_o
);

    // contents survive reset, as nonvolatile cells do
    genvar b;
    generate
        for (b = 0; b < ajs_pkg::SEL_W; b = b + 1)
        begin : g_lane
            // one byte array per lane, each with a single writer
            logic [7:0] cells [ajs_pkg::NV_WORDS];
            logic [7:0] rd_byte;
            always_ff @(posedge clk_i)
            begin
                if (ce_i && we_i && be_i[b])
                begin
                    cells[addr_i] <= wdata_i[8*b +: 8];
                end
            end
            always_ff @(posedge clk_i)
            begin
                if (ce_i)
                begin
                    rd_byte <= cells[addr_i];
                end
            end
            assign rdata_o[8*b +: 8] = rd_byte;
        end
    endgenerate

endmodule // ajs_nv_store

// ===== core/ajs_pkg.sv
// shared constants and types for the alternate test data input selector
package ajs_pkg;

    // register map, byte addresses on a 32-bit classic bus
    localparam int unsigned ADR_W          = 4;
    localparam logic [3:0]  ADR_STATUS     = 4'h0;
    localparam logic [3:0]  ADR_CONFIG     = 4'h4;
    localparam logic [3:0]  ADR_SIGNATURE  = 4'h8;
    localparam logic [3:0]  ADR_COMMAND    = 4'hC;

    // status register fields
    localparam int unsigned ST_ALT_BIT     = 0;
    localparam int unsigned ST_SEL_BIT     = 1;
    localparam int unsigned ST_FUSE_BIT    = 2;
    localparam int unsigned ST_APS_BIT     = 3;
    localparam int unsigned ST_CNT_LSB     = 4;
    localparam int unsigned ST_IR_LSB      = 8;

    // command register fields
    localparam int unsigned CMD_FUSE_BIT   = 0;
    localparam int unsigned CMD_ERASE_BIT  = 1;

    // nonvolatile word indexes
    localparam logic        NV_CONFIG      = 1'b0;
    localparam logic        NV_SIGNATURE   = 1'b1;
    localparam int unsigned NV_WORDS       = 2;
    localparam int unsigned WORD_W         = 32;
    localparam int unsigned SEL_W          = 4;

    // test port
    localparam int unsigned IR_W           = 8;
    localparam logic [7:0]  INSTR_IDCODE   = 8'h16;
    localparam int unsigned CNT_W          = 3;
    localparam logic [2:0]  ID_LOADS_NEED  = 3'h4;
    localparam logic [2:0]  CNT_ZERO       = 3'h0;
    localparam logic [2:0]  CNT_ONE        = 3'h1;
    // arbitrary identification value, names no maker
    localparam logic [31:0] ID_CODE_VALUE  = 32'h0A5C_3E71;

    // pins
    localparam int unsigned N_OUT          = 12;
    localparam int unsigned N_HV           = 2;
    localparam int unsigned N_IN           = 4;
    localparam int unsigned N_SYNC         = 6 + N_IN;

    // synchroniser bit positions
    localparam int unsigned SY_TCK         = 0;
    localparam int unsigned SY_TMS         = 1;
    localparam int unsigned SY_TDI         = 2;
    localparam int unsigned SY_ALT         = 3;
    localparam int unsigned SY_SEL         = 4;
    localparam int unsigned SY_APS         = 5;
    localparam int unsigned SY_IN_LSB      = 6;
    // select pin idles high because of its pull-up
    localparam logic [9:0]  SYNC_RST       = 10'h010;

    typedef enum logic [15:0] {
        TAP_RESET      = 16'h0001,
        TAP_IDLE       = 16'h0002,
        TAP_SEL_DR     = 16'h0004,
        TAP_CAP_DR     = 16'h0008,
        TAP_SHIFT_DR   = 16'h0010,
        TAP_EXIT1_DR   = 16'h0020,
        TAP_PAUSE_DR   = 16'h0040,
        TAP_EXIT2_DR   = 16'h0080,
        TAP_UPD_DR     = 16'h0100,
        TAP_SEL_IR     = 16'h0200,
        TAP_CAP_IR     = 16'h0400,
        TAP_SHIFT_IR   = 16'h0800,
        TAP_EXIT1_IR   = 16'h1000,
        TAP_PAUSE_IR   = 16'h2000,
        TAP_EXIT2_IR   = 16'h4000,
        TAP_UPD_IR     = 16'h8000
    } ajs_tap_type;

endpackage

// ===== core/ajs_select.sv
// test port with alternate data input selection, fuse and signature
//
// Functional notes
// - The select pin idles high through its pull-up; high picks the standard data input and low picks the alternate one.
// - With the select pin high, four consecutive identify instruction loads switch the data input to the alternate pin.
// - Once the alternate input is chosen the standard pin is ignored until the test state machine reaches its reset state.
// - The reset state of the test state machine loads the identify instruction automatically.
// - While only the programming supply is up, ordinary outputs float, gate drivers pull low and other inputs are ignored.
// - After the security fuse is set the functional configuration word can no longer be read back.
// - The security fuse clears only on rst_i or through an erase that also wipes the configuration.
// - A 32-bit user signature word is kept in nonvolatile storage.
// - Instruction code 0001 0110 is the identify instruction, which reads the 32-bit identification register.
`timescale 1ns/10ps
module ajs_select
(
    input  wire logic                        clk_i,
    input  wire logic                        rst_i,
    input  wire logic                        ce_i,
    input  wire logic                        wb_cyc_i,
    input  wire logic                        wb_stb_i,
    input  wire logic                        wb_we_i,
    input  wire logic [ajs_pkg::ADR_W-1:0]   wb_adr_i,
    input  wire logic [ajs_pkg::SEL_W-1:0]   wb_sel_i,
    input  wire logic [ajs_pkg::WORD_W-1:0]  wb_dat_i,
    output logic      [ajs_pkg::WORD_W-1:0]  wb_dat_o,
    output logic                             wb_ack_o,
    input  wire logic                        tck_i,
    input  wire logic                        tms_i,
    input  wire logic                        tdi_i,
    input  wire logic                        alternate_data_input_i,
    input  wire logic                        data_input_select_pin_i,
    output logic                             tdo_o,
    output logic                             tdo_oe_o,
    output logic                             alternate_active_o,
    input  wire logic                        alternate_programming_supply_i,
    input  wire logic [ajs_pkg::N_OUT-1:0]   core_out_i,
    input  wire logic [ajs_pkg::N_OUT-1:0]   core_oe_i,
    output logic      [ajs_pkg::N_OUT-1:0]   pin_out_o,
    output logic      [ajs_pkg::N_OUT-1:0]   pin_oe_o,
    input  wire logic [ajs_pkg::N_HV-1:0]    core_hv_i,
    output logic      [ajs_pkg::N_HV-1:0]    high_voltage_gate_output_o,
    input  wire logic [ajs_pkg::N_IN-1:0]    pin_in_i,
    output logic      [ajs_pkg::N_IN-1:0]    core_in_o
);

    logic [ajs_pkg::N_SYNC-1:0]  sync;
    logic                        tck_prev;
    logic                        tck_rise;
    logic                        tck_fall;
    logic                        sel_pin;
    logic                        aps_on;
    logic                        data_in;
    ajs_pkg::ajs_tap_type        tap;
    ajs_pkg::ajs_tap_type        next_tap;
    logic [ajs_pkg::IR_W-1:0]    ir_shift;
    logic [ajs_pkg::IR_W-1:0]    ir;
    logic [ajs_pkg::WORD_W-1:0]  dr_shift;
    logic [ajs_pkg::CNT_W-1:0]   id_count;
    logic                        alt_sel;
    logic                        fuse;
    logic                        bus_req;
    logic                        pend;
    logic                        wr_config;
    logic                        wr_signature;
    logic                        wr_command;
    logic                        do_erase;
    logic                        mem_we;
    logic                        mem_addr;
    logic [ajs_pkg::SEL_W-1:0]   mem_be;
    logic [ajs_pkg::WORD_W-1:0]  mem_wdata;
    logic [ajs_pkg::WORD_W-1:0]  mem_rdata;
    logic [ajs_pkg::WORD_W-1:0]  status_word;
    logic [ajs_pkg::WORD_W-1:0]  next_dat;

    ajs_sync
    #(
        .WIDTH   (ajs_pkg::N_SYNC),
        .RST_VAL (ajs_pkg::SYNC_RST)
    )
    u_sync
    (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .ce_i    (ce_i),
        .async_i ({pin_in_i, alternate_programming_supply_i,
                   data_input_select_pin_i, alternate_data_input_i,
                   tdi_i, tms_i, tck_i}),
        .sync_o  (sync)
    );

    assign sel_pin  = sync[ajs_pkg::SY_SEL];
    assign aps_on   = sync[ajs_pkg::SY_APS];
    assign tck_rise = sync[ajs_pkg::SY_TCK] & ~tck_prev;
    assign tck_fall = ~sync[ajs_pkg::SY_TCK] & tck_prev;

    // standard pin is used only while select is high and no switch happened
    always_comb
    begin
        if (!sel_pin || alt_sel)
        begin
            data_in = sync[ajs_pkg::SY_ALT];
        end
        else
        begin
            data_in = sync[ajs_pkg::SY_TDI];
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            tck_prev <= 1'b0;
        end
        else if (ce_i)
        begin
            tck_prev <= sync[ajs_pkg::SY_TCK];
        end
    end

    // test state machine; five mode-select highs always reach reset
    always_comb
    begin
        logic tms;
        tms = sync[ajs_pkg::SY_TMS];
        unique case (tap)
            ajs_pkg::TAP_RESET:
                next_tap = tms ? ajs_pkg::TAP_RESET : ajs_pkg::TAP_IDLE;
            ajs_pkg::TAP_IDLE:
                next_tap = tms ? ajs_pkg::TAP_SEL_DR : ajs_pkg::TAP_IDLE;
            ajs_pkg::TAP_SEL_DR:
                next_tap = tms ? ajs_pkg::TAP_SEL_IR : ajs_pkg::TAP_CAP_DR;
            ajs_pkg::TAP_CAP_DR:
                next_tap = tms ? ajs_pkg::TAP_EXIT1_DR : ajs_pkg::TAP_SHIFT_DR;
            ajs_pkg::TAP_SHIFT_DR:
                next_tap = tms ? ajs_pkg::TAP_EXIT1_DR : ajs_pkg::TAP_SHIFT_DR;
            ajs_pkg::TAP_EXIT1_DR:
                next_tap = tms ? ajs_pkg::TAP_UPD_DR : ajs_pkg::TAP_PAUSE_DR;
            ajs_pkg::TAP_PAUSE_DR:
                next_tap = tms ? ajs_pkg::TAP_EXIT2_DR : ajs_pkg::TAP_PAUSE_DR;
            ajs_pkg::TAP_EXIT2_DR:
                next_tap = tms ? ajs_pkg::TAP_UPD_DR : ajs_pkg::TAP_SHIFT_DR;
            ajs_pkg::TAP_UPD_DR:
                next_tap = tms ? ajs_pkg::TAP_SEL_DR : ajs_pkg::TAP_IDLE;
            ajs_pkg::TAP_SEL_IR:
                next_tap = tms ? ajs_pkg::TAP_RESET : ajs_pkg::TAP_CAP_IR;
            ajs_pkg::TAP_CAP_IR:
                next_tap = tms ? ajs_pkg::TAP_EXIT1_IR : ajs_pkg::TAP_SHIFT_IR;
            ajs_pkg::TAP_SHIFT_IR:
                next_tap = tms ? ajs_pkg::TAP_EXIT1_IR : ajs_pkg::TAP_SHIFT_IR;
            ajs_pkg::TAP_EXIT1_IR:
                next_tap = tms ? ajs_pkg::TAP_UPD_IR : ajs_pkg::TAP_PAUSE_IR;
            ajs_pkg::TAP_PAUSE_IR:
                next_tap = tms ? ajs_pkg::TAP_EXIT2_IR : ajs_pkg::TAP_PAUSE_IR;
            ajs_pkg::TAP_EXIT2_IR:
                next_tap = tms ? ajs_pkg::TAP_UPD_IR : ajs_pkg::TAP_SHIFT_IR;
            ajs_pkg::TAP_UPD_IR:
                next_tap = tms ? ajs_pkg::TAP_SEL_DR : ajs_pkg::TAP_IDLE;
            default:
                next_tap = ajs_pkg::TAP_RESET;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            tap <= ajs_pkg::TAP_RESET;
        end
        else if (ce_i && tck_rise)
        begin
            tap <= next_tap;
        end
    end

    // instruction path; capture preloads the identify code
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ir_shift <= ajs_pkg::INSTR_IDCODE;
            ir       <= ajs_pkg::INSTR_IDCODE;
        end
        else if (ce_i && tck_rise)
        begin
            unique case (tap)
                ajs_pkg::TAP_RESET:
                begin
                    ir       <= ajs_pkg::INSTR_IDCODE;
                    ir_shift <= ajs_pkg::INSTR_IDCODE;
                end
                ajs_pkg::TAP_CAP_IR:
                    ir_shift <= ajs_pkg::INSTR_IDCODE;
                ajs_pkg::TAP_SHIFT_IR:
                    ir_shift <= {data_in, ir_shift[ajs_pkg::IR_W-1:1]};
                ajs_pkg::TAP_UPD_IR:
                    ir       <= ir_shift;
                default:
                    ir_shift <= ir_shift;
            endcase
        end
    end

    // consecutive identify loads and the latched alternate choice
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            id_count <= ajs_pkg::CNT_ZERO;
            alt_sel  <= 1'b0;
        end
        else if (ce_i && tck_rise)
        begin
            if (tap == ajs_pkg::TAP_RESET)
            begin
                id_count <= ajs_pkg::CNT_ZERO;
                alt_sel  <= 1'b0;
            end
            else if (tap == ajs_pkg::TAP_UPD_IR)
            begin
                if (ir_shift != ajs_pkg::INSTR_IDCODE)
                begin
                    id_count <= ajs_pkg::CNT_ZERO;
                end
                else if (id_count != ajs_pkg::ID_LOADS_NEED)
                begin
                    id_count <= id_count + ajs_pkg::CNT_ONE;
                    if (sel_pin && (id_count + ajs_pkg::CNT_ONE
                                    == ajs_pkg::ID_LOADS_NEED))
                    begin
                        alt_sel <= 1'b1;
                    end
                end
            end
        end
    end

    // data path: identification register or one-bit bypass
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            dr_shift <= '0;
        end
        else if (ce_i && tck_rise)
        begin
            if (tap == ajs_pkg::TAP_CAP_DR)
            begin
                dr_shift <= (ir == ajs_pkg::INSTR_IDCODE) ?
                            ajs_pkg::ID_CODE_VALUE : '0;
            end
            else if (tap == ajs_pkg::TAP_SHIFT_DR)
            begin
                if (ir == ajs_pkg::INSTR_IDCODE)
                begin
                    dr_shift <= {data_in, dr_shift[ajs_pkg::WORD_W-1:1]};
                end
                else
                begin
                    dr_shift <= {{(ajs_pkg::WORD_W-1){1'b0}}, data_in};
                end
            end
        end
    end

    // serial output changes on the falling test clock edge
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            tdo_o    <= 1'b0;
            tdo_oe_o <= 1'b0;
        end
        else if (ce_i && tck_fall)
        begin
            tdo_oe_o <= (tap == ajs_pkg::TAP_SHIFT_IR) ||
                        (tap == ajs_pkg::TAP_SHIFT_DR);
            tdo_o    <= (tap == ajs_pkg::TAP_SHIFT_IR) ? ir_shift[0]
                                                        : dr_shift[0];
        end
    end

    // pin gating while only the programming supply is up
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pin_out_o                  <= '0;
            pin_oe_o                   <= '0;
            high_voltage_gate_output_o <= '0;
            core_in_o                  <= '0;
            alternate_active_o         <= 1'b0;
        end
        else if (ce_i)
        begin
            pin_out_o <= aps_on ? '0 : core_out_i;
            pin_oe_o  <= aps_on ? '0 : core_oe_i;
            high_voltage_gate_output_o <= aps_on ? '0 : core_hv_i;
            core_in_o <= aps_on ? '0 :
                         sync[ajs_pkg::SY_IN_LSB +: ajs_pkg::N_IN];
            alternate_active_o <= !sel_pin || alt_sel;
        end
    end

    // bus slave: request seen, registered as pending, then answered two cycles later
    assign bus_req      = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr_config    = wb_ack_o && wb_stb_i && wb_we_i && !fuse &&
                          (wb_adr_i == ajs_pkg::ADR_CONFIG);
    assign wr_signature = wb_ack_o && wb_stb_i && wb_we_i &&
                          (wb_adr_i == ajs_pkg::ADR_SIGNATURE);
    assign wr_command   = wb_ack_o && wb_stb_i && wb_we_i && wb_sel_i[0] &&
                          (wb_adr_i == ajs_pkg::ADR_COMMAND);
    assign do_erase     = wr_command && wb_dat_i[ajs_pkg::CMD_ERASE_BIT];

    always_comb
    begin
        mem_we    = wr_config || wr_signature || do_erase;
        mem_addr  = (wb_adr_i == ajs_pkg::ADR_SIGNATURE) && !do_erase ?
                    ajs_pkg::NV_SIGNATURE : ajs_pkg::NV_CONFIG;
        mem_be    = do_erase ? '1 : wb_sel_i;
        mem_wdata = do_erase ? '0 : wb_dat_i;
    end

    ajs_nv_store u_store
    (
        .clk_i   (clk_i),
        .ce_i    (ce_i),
        .we_i    (mem_we),
        .be_i    (mem_be),
        .addr_i  (mem_addr),
        .wdata_i (mem_wdata),
        .rdata_o (mem_rdata)
    );

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            fuse <= 1'b0;
        end
        else if (ce_i && wr_command)
        begin
            if (wb_dat_i[ajs_pkg::CMD_ERASE_BIT])
            begin
                fuse <= 1'b0;
            end
            else if (wb_dat_i[ajs_pkg::CMD_FUSE_BIT])
            begin
                fuse <= 1'b1;
            end
        end
    end

    always_comb
    begin
        status_word = '0;
        status_word[ajs_pkg::ST_ALT_BIT]  = !sel_pin || alt_sel;
        status_word[ajs_pkg::ST_SEL_BIT]  = sel_pin;
        status_word[ajs_pkg::ST_FUSE_BIT] = fuse;
        status_word[ajs_pkg::ST_APS_BIT]  = aps_on;
        status_word[ajs_pkg::ST_CNT_LSB +: ajs_pkg::CNT_W] = id_count;
        status_word[ajs_pkg::ST_IR_LSB +: ajs_pkg::IR_W]   = ir;
        unique case (wb_adr_i)
            ajs_pkg::ADR_STATUS:    next_dat = status_word;
            ajs_pkg::ADR_CONFIG:    next_dat = fuse ? '0 : mem_rdata;
            ajs_pkg::ADR_SIGNATURE: next_dat = mem_rdata;
            default:                next_dat = '0;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pend     <= 1'b0;
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end
        else if (ce_i)
        begin
            pend     <= bus_req && !pend;
            wb_ack_o <= pend;
            if (pend && !wb_we_i)
            begin
                wb_dat_o <= next_dat;
            end
        end
    end

endmodule // ajs_select

// ===== core/ajs_sync.sv
// two flip-flop synchronisers for asynchronous pin inputs
`timescale 1ns/10ps
module ajs_sync
#(
    parameter int unsigned     WIDTH   = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
)
(
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             ce_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);

    genvar b;
    generate
        for (b = 0; b < WIDTH; b = b + 1)
        begin : g_bit
            // per-bit stages, so each flip-flop has a single writer
            logic meta;
            logic held;
            always_ff @(posedge clk_i)
            begin
                if (rst_i)
                begin
                    meta <= RST_VAL[b];
                    held <= RST_VAL[b];
                end
                else if (ce_i)
                begin
                    meta <= async_i[b];
                    held <= meta;
                end
            end
            assign sync_o[b] = held;
        end
    endgenerate

endmodule // ajs_sync
